// [design/hpt_host_port.sv]
// Overview of operation
// - strobe is chip select OR data-strobe XNOR
// - select is access type, direction, halfword
// - address strobe unused is held high
// - first-half data read start fetches data, ready high
// - data write with full buffer drives not-ready
// - drive data only during reads
`timescale 1ns/10ps
`default_nettype none
module hpt_host_port
	import hpt_pkg::*;
#(
	parameter int DATA_W = HPT_DATA_W
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic sixteenBitMode,
	input wire logic hostChipSelectN,
	input wire logic hostDataStrobeA,
	input wire logic hostDataStrobeB,
	input wire logic hostAddressStrobeN,
	input wire logic [1:0] accessTypeSelect,
	input wire logic hostReadNotWrite,
	input wire logic halfwordSelect,
	input wire logic [DATA_W-1:0] hostDataBusIn,
	output logic [DATA_W-1:0] hostDataBusOut,
	output logic hostDataBusOe,
	output logic hostReadyN,
	output logic dmaReadReq,
	input wire logic dmaReadValid,
	input wire logic [DATA_W-1:0] dmaReadData,
	input wire logic writeBufferFull,
	output logic writeValid,
	output logic [DATA_W-1:0] writeData,
	output logic writeHalfword,
	output hpt_select_t accessSelect
);
	hpt_pins_t pinsRaw;
	hpt_pins_t pins;
	logic strobeN;
	logic strobeN_q, strobeN_d;
	logic asN_q, asN_d;
	logic asSeen_q, asSeen_d;
	hpt_state_t state_q, state_d;
	hpt_select_t sel_q, sel_d;
	hpt_select_t selNow;
	logic [DATA_W-1:0] rdData_q, rdData_d;
	logic [DATA_W-1:0] wrData_q, wrData_d;
	logic rdyN_q, rdyN_d;
	logic oe_q, oe_d;
	logic req_q, req_d;
	logic wv_q, wv_d;
	logic whw_q, whw_d;
	logic isRead, isData, firstHalf;
	hpt_select_t selTake;
	logic [DATA_W-1:0] dinMeta_q, dinMeta_d;
	logic [DATA_W-1:0] dinSync_q, dinSync_d;

	assign pinsRaw = '{hostChipSelectN, hostDataStrobeA, hostDataStrobeB, hostAddressStrobeN,
		'{accessTypeSelect, hostReadNotWrite, halfwordSelect}};

	hpt_sync u_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.pinsIn(pinsRaw),
		.pinsOut(pins)
	);

	// halfword select only qualifies in sixteen-bit mode
	always_comb
	begin
		strobeN = pins.hostChipSelectN | ~(pins.hostDataStrobeA ^ pins.hostDataStrobeB);
		selNow = pins.sel;
		if (!sixteenBitMode)
			selNow.halfwordSelect = 1'b0;
	end

	// selects a strobe fall would take now: the address-strobe copy once one is latched
	assign selTake = asSeen_q ? sel_q : selNow;
	assign isRead = selTake.hostReadNotWrite;
	assign isData = (selTake.accessTypeSelect == HPT_ACC_DATA);
	assign firstHalf = !sixteenBitMode || !selTake.halfwordSelect;

	// data pins pass the same two stages as the strobe, so the word taken at release
	// is the one that stood when the strobe rose
	always_comb
	begin
		dinMeta_d = dinMeta_q;
		dinSync_d = dinSync_q;
		if (clkEn)
		begin
			dinMeta_d = hostDataBusIn;
			dinSync_d = dinMeta_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dinMeta_q <= '0;
			dinSync_q <= '0;
		end
		else
		begin
			dinMeta_q <= dinMeta_d;
			dinSync_q <= dinSync_d;
		end
	end

	always_comb
	begin
		strobeN_d = strobeN_q;
		asN_d = asN_q;
		asSeen_d = asSeen_q;
		state_d = state_q;
		sel_d = sel_q;
		rdData_d = rdData_q;
		wrData_d = wrData_q;
		rdyN_d = rdyN_q;
		oe_d = oe_q;
		req_d = req_q;
		wv_d = wv_q;
		whw_d = whw_q;
		if (clkEn)
		begin
			req_d = 1'b0;
			wv_d = 1'b0;
			strobeN_d = strobeN;
			asN_d = pins.hostAddressStrobeN;
			// address strobe falls first: capture there, only once per access
			if (asN_q && !pins.hostAddressStrobeN && !asSeen_q)
			begin
				sel_d = selNow;
				asSeen_d = 1'b1;
			end
			if (strobeN_q && !strobeN)
			begin
				sel_d = selTake;
				if (isRead)
				begin
					oe_d = 1'b1;
					if (isData && firstHalf)
					begin
						req_d = 1'b1;
						rdyN_d = 1'b1;
						state_d = HPT_RD_WAIT;
					end
					else
					begin
						rdyN_d = 1'b0;
						state_d = HPT_ACTIVE;
					end
				end
				else
				begin
					rdyN_d = isData && writeBufferFull;
					state_d = HPT_ACTIVE;
				end
			end
			else
			begin
				unique case (state_q)
					HPT_IDLE:
						rdyN_d = HPT_RDY_N_RESET;
					HPT_RD_WAIT:
						if (dmaReadValid)
						begin
							rdData_d = dmaReadData;
							rdyN_d = 1'b0;
							state_d = HPT_ACTIVE;
						end
					HPT_ACTIVE:
					begin
						if (!sel_q.hostReadNotWrite && sel_q.accessTypeSelect == HPT_ACC_DATA)
							rdyN_d = writeBufferFull;
						// data captured on the rising edge; early release loses the write
						if (strobeN)
						begin
							if (!sel_q.hostReadNotWrite && !rdyN_q)
							begin
								wv_d = 1'b1;
								wrData_d = dinSync_q;
								whw_d = sel_q.halfwordSelect;
							end
							oe_d = 1'b0;
							rdyN_d = HPT_RDY_N_RESET;
							// the next access may drop its address strobe in this very cycle
							if (asN_q && !pins.hostAddressStrobeN)
								sel_d = selNow;
							else
								asSeen_d = 1'b0;
							state_d = HPT_DONE;
						end
					end
					HPT_DONE:
						state_d = HPT_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			strobeN_q <= 1'b1;
			asN_q <= 1'b1;
			asSeen_q <= 1'b0;
			state_q <= HPT_IDLE;
			sel_q <= HPT_SEL_RESET;
			rdData_q <= '0;
			wrData_q <= '0;
			rdyN_q <= HPT_RDY_N_RESET;
			oe_q <= 1'b0;
			req_q <= 1'b0;
			wv_q <= 1'b0;
			whw_q <= 1'b0;
		end
		else
		begin
			strobeN_q <= strobeN_d;
			asN_q <= asN_d;
			asSeen_q <= asSeen_d;
			state_q <= state_d;
			sel_q <= sel_d;
			rdData_q <= rdData_d;
			wrData_q <= wrData_d;
			rdyN_q <= rdyN_d;
			oe_q <= oe_d;
			req_q <= req_d;
			wv_q <= wv_d;
			whw_q <= whw_d;
		end
	end

	assign hostDataBusOut = rdData_q;
	assign hostDataBusOe = oe_q;
	assign hostReadyN = rdyN_q;
	assign dmaReadReq = req_q;
	assign writeValid = wv_q;
	assign writeData = wrData_q;
	assign writeHalfword = whw_q;
	assign accessSelect = sel_q;

	a_oe_only_read: assert property (@(posedge clk) disable iff (!rst_n)
		oe_q |-> sel_q.hostReadNotWrite) else $error("bus driven on write");
	a_oe_off_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == HPT_IDLE) |-> !oe_q) else $error("bus driven while idle");
	a_req_holds_rdy: assert property (@(posedge clk) disable iff (!rst_n)
		req_q |-> rdyN_q && state_q == HPT_RD_WAIT) else $error("ready low on fetch");
	a_wait_not_ready: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == HPT_RD_WAIT) |-> rdyN_q) else $error("ready low before data");
	a_fetch_loads: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == HPT_RD_WAIT && clkEn && dmaReadValid && !(strobeN_q && !strobeN))
		|=> !rdyN_q && rdData_q == $past(dmaReadData)) else $error("fetch not loaded");
	a_write_full: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == HPT_ACTIVE && clkEn && !strobeN && !sel_q.hostReadNotWrite
		&& sel_q.accessTypeSelect == HPT_ACC_DATA && writeBufferFull) |=> rdyN_q)
		else $error("ready with full buffer");
	a_write_needs_rdy: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wv_q) |-> $past(!rdyN_q)) else $error("write without ready");
	a_release_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == HPT_DONE) |=> state_q == HPT_IDLE || !clkEn) else $error("done stuck");
	a_half_gated: assert property (@(posedge clk) disable iff (!rst_n)
		(!sixteenBitMode && $changed(sel_q)) |-> !sel_q.halfwordSelect)
		else $error("halfword in 32-bit mode");
	a_as_once: assert property (@(posedge clk) disable iff (!rst_n)
		(asSeen_q && state_q != HPT_DONE) |=> asSeen_q || $past(state_q) == HPT_ACTIVE)
		else $error("address latch lost");

endmodule : hpt_host_port
`default_nettype wire

// [include/hpt_pkg.sv]
package hpt_pkg;

	localparam int HPT_DATA_W = 32;
	localparam int HPT_HALF_W = 16;
	localparam int HPT_WR_DEPTH = 4;
	localparam int HPT_SYNC_STAGES = 2;

	// access-type codes: only the data-register code fetches or waits on a full buffer; a write of any code pulses writeValid
	localparam logic [1:0] HPT_ACC_DATA = 2'h3;

	localparam logic [1:0] HPT_SYNC_RESET = 2'h3;
	localparam logic HPT_RDY_N_RESET = 1'h1;

	typedef struct packed {
		logic [1:0] accessTypeSelect;
		logic hostReadNotWrite;
		logic halfwordSelect;
	} hpt_select_t;

	localparam hpt_select_t HPT_SEL_RESET = '{2'h0, 1'h1, 1'h0};

	typedef struct packed {
		logic hostChipSelectN;
		logic hostDataStrobeA;
		logic hostDataStrobeB;
		logic hostAddressStrobeN;
		hpt_select_t sel;
	} hpt_pins_t;

	localparam hpt_pins_t HPT_PINS_RESET = '{1'h1, 1'h0, 1'h0, 1'h1, HPT_SEL_RESET};

	typedef enum logic [1:0] {
		HPT_IDLE = 2'b00,
		HPT_RD_WAIT = 2'b01,
		HPT_ACTIVE = 2'b10,
		HPT_DONE = 2'b11
	} hpt_state_t;

endpackage : hpt_pkg

// [design/hpt_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for the pin bundle
module hpt_sync
	import hpt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire hpt_pins_t pinsIn,
	output hpt_pins_t pinsOut
);
	hpt_pins_t meta_q;
	hpt_pins_t meta_d;
	hpt_pins_t sync_q;
	hpt_pins_t sync_d;

	always_comb
	begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (clkEn)
		begin
			meta_d = pinsIn;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= HPT_PINS_RESET;
			sync_q <= HPT_PINS_RESET;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign pinsOut = sync_q;

endmodule : hpt_sync
`default_nettype wire

// [tb/hpt_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hpt_host_model
	import hpt_pkg::*;
(
	input wire logic clk,
	input wire logic rdyN,
	input wire logic oe,
	input wire logic [31:0] dOut,
	output hpt_pins_t pins,
	output logic [31:0] dIn
);
	initial
	begin
		pins = HPT_PINS_RESET; // address strobe idles high
		dIn = 32'h0;
	end
	task automatic access(input logic rnw, useAs, input logic [1:0] code, input logic half,
		input logic [31:0] wd, output int n, output logic [31:0] rd, output logic rOe);
		@(posedge clk);
		pins.sel <= '{code, rnw, half};
		pins.hostChipSelectN <= 1'b0;
		dIn <= rnw ? ~dIn : wd;
		if (useAs)
		begin
			@(posedge clk) pins.hostAddressStrobeN <= 1'b0; // one pulse only
			@(posedge clk) pins.hostAddressStrobeN <= 1'b1;
			pins.sel <= ~pins.sel; // legal after hold, exposes late latching
		end
		@(posedge clk) pins.hostDataStrobeA <= 1'b1; // strobes differ
		for (n = 0; rdyN !== 1'b0 && n < 60; n++) @(posedge clk);
		rd = dOut;
		rOe = oe;
		{pins.hostChipSelectN, pins.hostDataStrobeA} <= 2'b10;
		repeat (4) @(posedge clk);
		dIn <= ~dIn; // stale data would hide a late sample
		repeat (2) @(posedge clk);
	endtask : access
	task automatic bogus(input logic [2:0] c, output logic act);
		act = 1'b0;
		@(posedge clk) {pins.hostChipSelectN, pins.hostDataStrobeA, pins.hostDataStrobeB} <= c;
		repeat (8) @(posedge clk) act |= oe | ~rdyN;
		{pins.hostChipSelectN, pins.hostDataStrobeA, pins.hostDataStrobeB} <= 3'b100;
		repeat (4) @(posedge clk);
	endtask : bogus
endmodule : hpt_host_model
`default_nettype wire

// [tb/host_port_handshake_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module host_port_handshake_bench
	import hpt_pkg::*;
;
	logic clk, rst_n, mode16, oe, rdyN, req, dmaValid, bufFull, wValid, wHalf, lastH, o, act;
	logic [31:0] dOut, hostBus, wData, lastW, rd;
	logic [4:0] pipe;
	hpt_pins_t pins;
	hpt_select_t accSel;
	int nMismatch, nTests, nReq, nWr, n, r0;
	localparam logic [31:0] FETCHED = 32'hA5C3_0F96;
	wire logic [31:0] busIn = oe ? dOut : hostBus;
	hpt_host_port DUT (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .sixteenBitMode(mode16),
		.hostChipSelectN(pins.hostChipSelectN), .hostDataStrobeA(pins.hostDataStrobeA),
		.hostDataStrobeB(pins.hostDataStrobeB), .hostAddressStrobeN(pins.hostAddressStrobeN),
		.accessTypeSelect(pins.sel.accessTypeSelect), .hostReadNotWrite(pins.sel.hostReadNotWrite),
		.halfwordSelect(pins.sel.halfwordSelect), .hostDataBusIn(busIn), .hostDataBusOut(dOut),
		.hostDataBusOe(oe), .hostReadyN(rdyN), .dmaReadReq(req), .dmaReadValid(dmaValid),
		.dmaReadData(FETCHED), .writeBufferFull(bufFull), .writeValid(wValid), .writeData(wData),
		.writeHalfword(wHalf), .accessSelect(accSel));
	hpt_host_model host (.clk(clk), .rdyN(rdyN), .oe(oe), .dOut(dOut), .pins(pins), .dIn(hostBus));
	always #25 clk = ~clk;
	// fetch answers six cycles after the request
	always @(posedge clk)
	begin
		pipe <= {pipe[3:0], req};
		dmaValid <= pipe[4];
		nReq += req;
		nWr += wValid;
		if (wValid)
		begin
			lastW <= wData;
			lastH <= wHalf;
		end
	end
	task check(input logic [31:0] seen, exp);
		nTests++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task stop_test;
		$display("checks %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task t_decode;
		logic [2:0] c [4];
		c = '{3'b110, 3'b000, 3'b011, 3'b001};
		foreach (c[i])
		begin
			host.bogus(c[i], act);
			check(act, !c[i][2] && (c[i][1] ^ c[i][0]));
		end
	endtask : t_decode
	task t_read32;
		r0 = nReq;
		host.access(1'b1, 1'b0, HPT_ACC_DATA, 1'b0, 32'h0, n, rd, o);
		check(rd, FETCHED);
		check(n > 7, 1);
		check(nReq - r0, 1);
		check(o, 1);
		check(oe, 0);
	endtask : t_read32
	task t_write_full;
		r0 = nWr;
		bufFull <= 1'b1;
		fork
			begin
				repeat (12) @(posedge clk);
				bufFull <= 1'b0;
			end
		join_none
		host.access(1'b0, 1'b0, HPT_ACC_DATA, 1'b0, 32'h1234_ABCD, n, rd, o);
		check(n > 8, 1);
		check(o, 0);
		check(nWr - r0, 1);
		check(lastW, 32'h1234_ABCD);
	endtask : t_write_full
	task t_sixteen;
		r0 = nReq;
		mode16 <= 1'b1;
		host.access(1'b1, 1'b1, HPT_ACC_DATA, 1'b1, 32'h0, n, rd, o);
		check(nReq - r0, 0);
		check(accSel, {HPT_ACC_DATA, 2'b11});
		check(o, 1);
		host.access(1'b0, 1'b0, HPT_ACC_DATA, 1'b1, 32'h0000_5A5A, n, rd, o);
		check(accSel, {HPT_ACC_DATA, 2'b01});
		check(lastH, 1);
		check(lastW, 32'h0000_5A5A);
		check(n < 8, 1);
		mode16 <= 1'b0;
	endtask : t_sixteen
	initial
	begin
		clk = 1'b0;
		{rst_n, mode16, bufFull, dmaValid} = 4'h0;
		pipe = 5'h0;
		{nMismatch, nTests, nReq, nWr} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_decode;
		t_read32;
		t_write_full;
		t_sixteen;
		stop_test;
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		nMismatch++;
		stop_test;
	end
endmodule : host_port_handshake_bench
`default_nettype wire
